// file: hdl/outgoing_trib_marker_gen.sv
`timescale 1ns/100ps

// first-in first-out buffer of flip-flops, valid and ready on both sides
// a full buffer refuses its write side, so nothing offered is ever dropped
// the read side shows the oldest word for as long as it is not taken
// depth need not be a power of two; the count tells full from empty
module marker_fifo #(
	parameter int WIDTH = 56,
	parameter int DEPTH = 8
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [WIDTH-1:0] wr_data_in,
	input wire logic wr_valid_in,
	output logic wr_ready_out,
	output logic [WIDTH-1:0] rd_data_out,
	output logic rd_valid_out,
	input wire logic rd_ready_in
);
	// the count needs one bit more than the pointers to tell full from empty
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW:0] DEPTH_CNT = AW'(DEPTH) == '0 ? {1'h1, {AW{1'h0}}} : (AW + 1)'(DEPTH);

	// storage, pointers and occupancy
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [WIDTH-1:0] nxt_mem [DEPTH];
	logic [AW-1:0] wr_ptr_ff, nxt_wr_ptr;
	logic [AW-1:0] rd_ptr_ff, nxt_rd_ptr;
	logic [AW:0] count_ff, nxt_count;
	logic do_wr, do_rd;

	// pointers wrap at DEPTH, which need not be a power of two
	function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
		ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'h1;
	endfunction

	// full and empty come straight from the occupancy count
	assign wr_ready_out = (count_ff != DEPTH_CNT);
	assign rd_valid_out = (count_ff != '0);
	assign rd_data_out = mem_ff[rd_ptr_ff]; // head shown with no read delay

	// a transfer happens on each side where valid meets ready
	assign do_wr = wr_valid_in && wr_ready_out;
	assign do_rd = rd_valid_out && rd_ready_in;

	// pointer and count arithmetic
	always_comb begin
		nxt_wr_ptr = do_wr ? ptr_inc(wr_ptr_ff) : wr_ptr_ff;
		nxt_rd_ptr = do_rd ? ptr_inc(rd_ptr_ff) : rd_ptr_ff;
		nxt_count = count_ff;
		// a write and a read in one cycle leave the count as it is
		if (do_wr && !do_rd) begin
			nxt_count = count_ff + 1'h1;
		end else if (do_rd && !do_wr) begin
			nxt_count = count_ff - 1'h1;
		end
	end

	// pointers and count clear on reset so the buffer starts empty
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff <= '0;
		end else begin
			wr_ptr_ff <= nxt_wr_ptr;
			rd_ptr_ff <= nxt_rd_ptr;
			count_ff <= nxt_count;
		end
	end

	// storage needs no reset; an entry is only read after it was written
	always_comb begin
		nxt_mem = mem_ff;
		if (do_wr) begin
			nxt_mem[wr_ptr_ff] = wr_data_in;
		end
	end

	// the whole array registers its next value; only the written entry changes
	always_ff @(posedge clk_in) begin
		mem_ff <= nxt_mem;
	end
endmodule

// outgoing marker generator: buffers the outgoing words and tags each byte
// lane with its path overhead and idle markers for the selected lane mode
// lane i of the byte bus is byte lane i, lane 0 on the low byte
// one clock serves both modes; the single-lane mode runs at this same rate,
// a limitation the user must plan the clock for
module outgoing_trib_marker_gen #(
	parameter int DEPTH = trib_marker_pkg::FIFO_DEPTH
) (
	input wire logic CLK_IN,
	input wire logic SYS_RST_IN,
	input wire logic OUTGOING_LANE_MODE_SEL_IN,
	input wire trib_marker_pkg::stream_word_t STREAM_IN,
	input wire logic STREAM_VALID_IN,
	output logic STREAM_READY_OUT,
	output logic [31:0] OUTGOING_BYTE_BUS_OUT,
	output logic [3:0] PATH_OVERHEAD_MARKER_OUT,
	output logic [3:0] IDLE_MARKER_OUT,
	output logic OUT_VALID_OUT,
	input wire logic OUT_READY_IN
);
	import trib_marker_pkg::*;

	// one buffer entry holds all four lanes with their side information
	localparam int WORD_W = $bits(stream_word_t);

	// buffer read side and the decoded mode
	logic [WORD_W-1:0] fifo_rd_data;
	stream_word_t head;
	logic fifo_rd_valid, fifo_rd_ready;
	logic four_lane;

	// output stage registers, their next values and the lane enables
	logic valid_ff, nxt_valid;
	logic [31:0] bus_ff, nxt_bus;
	logic [3:0] poh_ff, nxt_poh;
	logic [3:0] idle_ff, nxt_idle;
	logic [3:0] lane_ok;

	// overhead byte class depends on whether the tributary is carried as TU3
	// transport overhead and payload bytes never mark, in either class
	function automatic logic is_path_oh(input byte_kind_t kind, input logic tu3);
		if (tu3) begin
			is_path_oh = kind inside {BYTE_J1, BYTE_B3, BYTE_C2, BYTE_G1, BYTE_F2, BYTE_H4,
				BYTE_Z3, BYTE_Z4, BYTE_Z5};
		end else begin
			is_path_oh = kind inside {BYTE_V5, BYTE_J2, BYTE_Z6, BYTE_Z7};
		end
	endfunction

	// buffer absorbs downstream stalls; its ready is the upstream back-pressure
	// that ready is combinational, so a full buffer refuses in the same cycle
	marker_fifo #(
		.WIDTH(WORD_W),
		.DEPTH(DEPTH)
	) u_fifo (
		.clk_in(CLK_IN),
		.rst_in(SYS_RST_IN),
		.wr_data_in(STREAM_IN),
		.wr_valid_in(STREAM_VALID_IN),
		.wr_ready_out(STREAM_READY_OUT),
		.rd_data_out(fifo_rd_data),
		.rd_valid_out(fifo_rd_valid),
		.rd_ready_in(fifo_rd_ready)
	);

	// view the buffer head as lanes again and decode the mode level
	assign head = stream_word_t'(fifo_rd_data);
	assign four_lane = (OUTGOING_LANE_MODE_SEL_IN == MODE_FOUR_LANE);

	// output stage refills when empty or when its word is being taken;
	// taking and reloading share one edge, so words flow one a cycle
	assign fifo_rd_ready = !valid_ff || OUT_READY_IN;

	// lanes 2 to 4 carry meaning only with four STM-1 lanes
	// with one STM-4 lane they hold no stream, so their enables stay low
	always_comb begin
		lane_ok = {four_lane, four_lane, four_lane, 1'h1};
	end

	// marker computation for the word leaving the buffer; the mode is sampled
	// here, so a change with words still queued marks them by the new mode
	always_comb begin
		nxt_valid = valid_ff;
		nxt_bus = bus_ff;
		nxt_poh = poh_ff;
		nxt_idle = idle_ff;
		// a stalled word holds bus and markers together until it is taken
		if (fifo_rd_ready) begin
			nxt_valid = fifo_rd_valid;
			if (fifo_rd_valid) begin
				for (int i = 0; i < LANE_CNT; i++) begin
					// bytes pass through every lane in both modes
					nxt_bus[i*LANE_W +: LANE_W] = head[i].data;
					// lane 1 in either mode, lanes 2-4 per lane in four-lane mode
					nxt_poh[i] = lane_ok[i] && is_path_oh(head[i].kind, head[i].tu3);
					nxt_idle[i] = lane_ok[i] && head[i].idle;
				end
				// invalid lanes forced low so nothing spurious leaks downstream
				nxt_poh = nxt_poh & lane_ok;
				nxt_idle = nxt_idle & lane_ok;
			end
		end
	end

	// one clock for both modes; the marker moves with its byte
	// reset clears the stage so no marker shows before the first word
	always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			valid_ff <= RST_VALID;
			bus_ff <= RST_BUS;
			poh_ff <= RST_MARK;
			idle_ff <= RST_MARK;
		end else begin
			valid_ff <= nxt_valid;
			bus_ff <= nxt_bus;
			poh_ff <= nxt_poh;
			idle_ff <= nxt_idle;
		end
	end

	// outputs come straight from the stage registers
	assign OUT_VALID_OUT = valid_ff;
	assign OUTGOING_BYTE_BUS_OUT = bus_ff;
	assign PATH_OVERHEAD_MARKER_OUT = poh_ff;
	assign IDLE_MARKER_OUT = idle_ff;
endmodule

// file: hdl/trib_marker_pkg.sv
package trib_marker_pkg;
	// number of outgoing byte lanes and width of one lane
	localparam int LANE_CNT = 4;
	localparam int LANE_W = 8;
	// words of buffering ahead of the marker stage
	localparam int FIFO_DEPTH = 8;
	// reset values of the output stage
	localparam logic RST_VALID = 1'h0;
	localparam logic [31:0] RST_BUS = 32'h0000_0000;
	localparam logic [3:0] RST_MARK = 4'h0;
	// level of the mode input that selects four STM-1 lanes
	localparam logic MODE_FOUR_LANE = 1'h1;

	// identity of the byte carried on a lane, tagged upstream
	typedef enum logic [3:0] {
		BYTE_PAYLOAD = 4'h0,
		BYTE_TOH = 4'h1,
		BYTE_J1 = 4'h2,
		BYTE_B3 = 4'h3,
		BYTE_C2 = 4'h4,
		BYTE_G1 = 4'h5,
		BYTE_F2 = 4'h6,
		BYTE_H4 = 4'h7,
		BYTE_Z3 = 4'h8,
		BYTE_Z4 = 4'h9,
		BYTE_Z5 = 4'hA,
		BYTE_V5 = 4'hB,
		BYTE_J2 = 4'hC,
		BYTE_Z6 = 4'hD,
		BYTE_Z7 = 4'hE
	} byte_kind_t;

	// one lane of the outgoing stream with its side information
	typedef struct packed {
		logic [7:0] data;
		byte_kind_t kind;
		logic idle;
		logic tu3;
	} lane_word_t;

	typedef lane_word_t [3:0] stream_word_t;
endpackage

// file: verif/outgoing_trib_marker_gen_chk.sv
`timescale 1ns/100ps
module outgoing_trib_marker_gen_chk #(parameter int DEPTH = 8) (
	input wire logic CLK_IN,
	input wire logic SYS_RST_IN,
	input wire logic OUTGOING_LANE_MODE_SEL_IN,
	input wire logic STREAM_VALID_IN,
	input wire logic STREAM_READY_OUT,
	input wire logic [31:0] OUTGOING_BYTE_BUS_OUT,
	input wire logic [3:0] PATH_OVERHEAD_MARKER_OUT,
	input wire logic [3:0] IDLE_MARKER_OUT,
	input wire logic OUT_VALID_OUT,
	input wire logic OUT_READY_IN
);
	default clocking @(posedge CLK_IN);
	endclocking
	default disable iff (SYS_RST_IN);
	// words inside the block: taken at the input and not yet taken at the output
	int held_cnt_ff;
	always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			held_cnt_ff <= 0;
		end else begin
			held_cnt_ff <= held_cnt_ff + int'(STREAM_VALID_IN && STREAM_READY_OUT)
				- int'(OUT_VALID_OUT && OUT_READY_IN);
		end
	end
	// refusal only when the buffer and the output stage are all occupied
	AST_CAPACITY: assert property (!STREAM_READY_OUT == (held_cnt_ff == DEPTH + 1))
		else $error("refusal not at capacity");
	// mode only moves while the pipeline is empty, so its present level governs the shown word
	AST_IDLE_ONE: assert property (!OUTGOING_LANE_MODE_SEL_IN && OUT_VALID_OUT
		|-> IDLE_MARKER_OUT[3:1] == 3'h0) else $error("idle upper lanes set");
	AST_POH_ONE: assert property (!OUTGOING_LANE_MODE_SEL_IN && OUT_VALID_OUT
		|-> PATH_OVERHEAD_MARKER_OUT[3:1] == 3'h0) else $error("marker upper lanes set");
	AST_HOLD_BUS: assert property (OUT_VALID_OUT && !OUT_READY_IN
		|=> OUT_VALID_OUT && $stable(OUTGOING_BYTE_BUS_OUT)) else $error("bus moved in stall");
	AST_HOLD_MARK: assert property (OUT_VALID_OUT && !OUT_READY_IN
		|=> $stable(PATH_OVERHEAD_MARKER_OUT) && $stable(IDLE_MARKER_OUT)) else $error("marker moved");
	AST_REFUSE: assert property (!STREAM_READY_OUT |-> OUT_VALID_OUT) else $error("refused too early");
	AST_LATENCY: assert property (STREAM_VALID_IN && STREAM_READY_OUT && !OUT_VALID_OUT
		|-> ##2 OUT_VALID_OUT) else $error("answer late");
	AST_ROOM: assert property ($rose(STREAM_READY_OUT)
		|-> $past(OUT_VALID_OUT && OUT_READY_IN)) else $error("room without drain");
	AST_FULL: assert property ($fell(STREAM_READY_OUT) |-> $past(STREAM_VALID_IN)) else $error("full without take");
endmodule

// file: verif/downstream_sink.sv
`timescale 1ns/100ps
// consumer of the byte bus; it drives only the ready, and the bench checks that the unused marker lanes read low
module downstream_sink (
	input wire logic clk_in,
	input wire logic slow_in,
	output logic ready_out
);
	logic [1:0] cnt_ff = 2'h0;
	// a slow consumer takes one word in four, so the buffer backs up
	always_ff @(posedge clk_in) begin
		cnt_ff <= cnt_ff + 2'h1;
	end
	assign ready_out = ~slow_in | (cnt_ff == 2'h3);
endmodule

// file: verif/outgoing_trib_marker_gen_tb.sv
`timescale 1ns/100ps
module outgoing_trib_marker_gen_tb;
	import trib_marker_pkg::*;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic mode = 1'h1;
	logic vin = 1'h0;
	logic slow = 1'h0;
	stream_word_t w = '0;
	logic rdy, vo, ro;
	logic [31:0] bus;
	logic [3:0] poh, idle;
	int bad_count = 0;
	int check_count = 0;
	logic [39:0] q[$];
	// 25 ns period
	always #12.5 clk = ~clk;
	outgoing_trib_marker_gen i_dut (.CLK_IN(clk), .SYS_RST_IN(rst), .OUTGOING_LANE_MODE_SEL_IN(mode), .STREAM_IN(w),
		.STREAM_VALID_IN(vin), .STREAM_READY_OUT(rdy), .OUTGOING_BYTE_BUS_OUT(bus),
		.PATH_OVERHEAD_MARKER_OUT(poh), .IDLE_MARKER_OUT(idle), .OUT_VALID_OUT(vo), .OUT_READY_IN(ro));
	downstream_sink i_sink (.clk_in(clk), .slow_in(slow), .ready_out(ro));
	task report_and_stop;
		$display("checks %0d errors %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task cmp(input logic [39:0] got, input logic [39:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %0t got %h want %h", $time, got, exp);
		end
	endtask
	task step(inout int n);
		@(posedge clk);
		n++;
		if (n > 999) begin
			bad_count++;
			report_and_stop;
		end
	endtask
	// bytes pass in every lane; markers only in lanes valid for the mode
	function automatic logic [39:0] want(stream_word_t s);
		logic [39:0] r;
		for (int i = 0; i < 4; i++) begin
			r[8*i+8+:8] = s[i].data;
			r[4+i] = (mode | i == 0) &
				(s[i].tu3 ? s[i].kind inside {[BYTE_J1:BYTE_Z5]} : s[i].kind inside {[BYTE_V5:BYTE_Z7]});
			r[i] = (mode | i == 0) & s[i].idle;
		end
		return r;
	endfunction
	// each accepted word is compared with the oldest word sent
	always @(posedge clk) begin
		if (vo === 1'h1 && ro === 1'h1)
			cmp({bus, poh, idle}, q.size() > 0 ? q.pop_front() : 40'hX);
	end
	// every byte kind under both tributary modes, back to back, then drain
	task burst;
		stream_word_t s;
		int n;
		n = 0;
		for (int k = 0; k < 30; k++) begin
			for (int i = 0; i < 4; i++)
				s[i] = '{8'(k * 4 + i), byte_kind_t'(k % 15), 1'(k + i), k >= 15};
			w <= s;
			vin <= 1'h1;
			q.push_back(want(s));
			do step(n); while (rdy !== 1'h1);
		end
		vin <= 1'h0;
		while (q.size() > 0) step(n);
	endtask
	task reset_values;
		cmp({bus, poh, idle}, 40'h0);
		cmp({38'h0, rdy, vo}, 40'h2);
	endtask
	task four_lane_prompt;
		mode <= 1'h1;
		slow <= 1'h0;
		@(posedge clk);
		burst;
	endtask
	task single_lane_slow;
		mode <= 1'h0;
		slow <= 1'h1;
		@(posedge clk);
		burst;
	endtask
	initial begin
		repeat (10) @(posedge clk);
		reset_values;
		rst <= 1'h0;
		four_lane_prompt;
		single_lane_slow;
		report_and_stop;
	end
endmodule
bind outgoing_trib_marker_gen outgoing_trib_marker_gen_chk #(.DEPTH(DEPTH)) i_chk (.CLK_IN, .SYS_RST_IN,
	.OUTGOING_LANE_MODE_SEL_IN, .STREAM_VALID_IN, .STREAM_READY_OUT, .OUTGOING_BYTE_BUS_OUT,
	.PATH_OVERHEAD_MARKER_OUT, .IDLE_MARKER_OUT, .OUT_VALID_OUT, .OUT_READY_IN);
